// file: pkg/rtmoc_map.svh
// register map, field positions, mode codes and sizes of the rt option control block
`ifndef RTMOC_MAP_SVH
`define RTMOC_MAP_SVH

// ****************************************************************
// register indices
// ****************************************************************
`define RTMOC_ADDR_CFG1            6'h00
`define RTMOC_ADDR_STS             6'h01
`define RTMOC_ADDR_OPT             6'h17
`define RTMOC_ADDR_BITW            6'h1E
`define RTMOC_ADDR_ALTW            6'h1F

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define RTMOC_CFG1_TERMINAL_EXECUTE_ENABLE 15
`define RTMOC_CFG1_TX_INHIBIT_BUS_A        13
`define RTMOC_CFG1_TX_INHIBIT_BUS_B        12
`define RTMOC_CFG1_SHUTDOWN_TX_ONLY        11
`define RTMOC_OPT_RX_STAGING_BUFFER_EN     6
`define RTMOC_OPT_ALT_SELFTEST_WORD_SEL    5
`define RTMOC_OPT_HOST_HANDLED_SHUTDOWN    4
`define RTMOC_OPT_AUTO_RESET_ON_CODE8_OFF  0
`define RTMOC_OPT_MASK                     16'h0071
`define RTMOC_STS_TERMINAL_SOFT_RESET      0
`define RTMOC_RESET_WORD                   16'h0000

// ****************************************************************
// mode codes
// ****************************************************************
`define RTMOC_MC_TX_SHUTDOWN       5'h04
`define RTMOC_MC_TX_OVERRIDE       5'h05
`define RTMOC_MC_RESET_TERMINAL    5'h08
`define RTMOC_MC_TX_SELFTEST_WORD  5'h13
`define RTMOC_MC_SEL_SHUTDOWN      5'h14
`define RTMOC_MC_SEL_OVERRIDE      5'h15

// ****************************************************************
// sizes
// ****************************************************************
`define RTMOC_STAGE_DEPTH          32
`define RTMOC_BUF_DEPTH            2
`define RTMOC_WORD_W               16

`endif

// file: pkg/rtmoc_pkg.sv
// types shared by the rt option control block
package rtmoc_pkg;

   // ****************************************************************
   // staging sequencer
   // ****************************************************************
   typedef enum logic {
      STG_FILL,
      STG_COPY
   } rtmoc_stage_t;

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic [4:0]  code;
      logic        bus;
      logic        bcast;
      logic        match;
   } rtmoc_mc_t;

   typedef struct packed {
      logic [4:0]  idx;
      logic [15:0] data;
   } rtmoc_memwr_t;

endpackage

// file: hdl/rtmoc_skid_buf.sv
// small fifo in the receive word path with valid and ready on both sides
`timescale 1ns/1ns
module rtmoc_skid_buf #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 2
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic             inValid,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  inReady,
   output logic                  outValid,
   output logic [WIDTH-1:0]      outData,
   input  wire logic             outReady
);
   import rtmoc_pkg::*;

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wrPtr;
      logic [AW-1:0]               rdPtr;
      logic [AW:0]                 count;
      logic                        notFull;
      logic                        notEmpty;
   } rtmoc_buf_t;

   rtmoc_buf_t s;
   rtmoc_buf_t next_s;
   logic       push;
   logic       pop;

   always_comb begin
      next_s = s;
      push   = inValid && s.notFull;
      pop    = outReady && s.notEmpty;
      if (push) begin
         next_s.mem[s.wrPtr] = inData;
         next_s.wrPtr = (s.wrPtr == AW'(DEPTH - 1)) ? '0 : s.wrPtr + 1'b1;
      end
      if (pop) begin
         next_s.rdPtr = (s.rdPtr == AW'(DEPTH - 1)) ? '0 : s.rdPtr + 1'b1;
      end
      next_s.count    = s.count + (AW+1)'(push) - (AW+1)'(pop);
      // ready is registered, so a full buffer refuses the word rather than overrunning
      next_s.notFull  = (next_s.count != (AW+1)'(DEPTH));
      next_s.notEmpty = (next_s.count != '0);
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign inReady  = s.notFull;
   assign outValid = s.notEmpty;
   assign outData  = s.mem[s.rdPtr];
endmodule

// file: hdl/rtmoc_top.sv
// rt option control: receive staging, self-test word select, bus shutdown handling
`timescale 1ns/1ns
`include "rtmoc_map.svh"
module rtmoc_top #(
   parameter int STAGE_DEPTH = `RTMOC_STAGE_DEPTH,
   parameter int BUF_DEPTH   = `RTMOC_BUF_DEPTH
) (
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   input  wire logic                   master_reset_n,
   input  wire logic [5:0]             regAddr,
   input  wire logic [15:0]            regWdata,
   input  wire logic                   regWr,
   input  wire logic                   regRd,
   output logic [15:0]                 regRdata,
   input  wire logic                   rxWordValid,
   input  wire logic [15:0]            rxWord,
   output logic                        rxWordReady,
   input  wire logic                   msgEnd,
   input  wire logic                   msgErr,
   input  wire logic                   mcValid,
   input  wire rtmoc_pkg::rtmoc_mc_t   mc,
   input  wire logic                   statusDone,
   input  wire logic                   txInhibitPinA,
   input  wire logic                   txInhibitPinB,
   output logic                        memWrValid,
   output rtmoc_pkg::rtmoc_memwr_t     memWr,
   input  wire logic                   memWrReady,
   output logic                        txEnA,
   output logic                        txEnB,
   output logic                        rxEnA,
   output logic                        rxEnB,
   output logic [15:0]                 bitWordOut,
   output logic                        bitWordReq,
   output logic                        statusOnlyResp,
   output logic                        terminalReset
);
   import rtmoc_pkg::*;

   localparam int CW = $clog2(STAGE_DEPTH) + 1;

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic [15:0]                  cfg1;
      logic [15:0]                  opt;
      logic [11:0]                  bitLow;
      logic [15:0]                  altWord;
      logic                         txOffA;
      logic                         txOffB;
      logic                         rxOffA;
      logic                         rxOffB;
      rtmoc_stage_t                 stage;
      logic [CW-1:0]                cnt;
      logic [CW-1:0]                copyIdx;
      logic                         endPend;
      logic                         endErr;
      logic                         resetPend;
      logic [STAGE_DEPTH-1:0][15:0] stageMem;
      logic                         memWrValid;
      rtmoc_memwr_t                 memWr;
      logic [15:0]                  rdData;
      logic                         txEnA;
      logic                         txEnB;
      logic                         rxEnA;
      logic                         rxEnB;
      logic [15:0]                  bitWordOut;
      logic                         bitReq;
      logic                         stsOnly;
      logic                         termReset;
   } rtmoc_state_t;

   rtmoc_state_t s;
   rtmoc_state_t next_s;

   logic        hardRst_b;
   logic        bufOutValid;
   logic [15:0] bufOutData;
   logic        bufPop;
   logic        outFree;
   logic        softRst;
   logic        termRst;
   logic        stagingOn;
   logic        hostBsd;

   // ****************************************************************
   // command decoding
   // ****************************************************************
   function automatic logic isShutdown(input rtmoc_mc_t c);
      return (c.code == `RTMOC_MC_TX_SHUTDOWN) ||
             ((c.code == `RTMOC_MC_SEL_SHUTDOWN) && c.match);
   endfunction

   function automatic logic isOverride(input rtmoc_mc_t c);
      return (c.code == `RTMOC_MC_TX_OVERRIDE) ||
             ((c.code == `RTMOC_MC_SEL_OVERRIDE) && c.match);
   endfunction

   function automatic logic isBusCmd(input rtmoc_mc_t c);
      return (c.code == `RTMOC_MC_TX_SHUTDOWN) || (c.code == `RTMOC_MC_TX_OVERRIDE) ||
             (c.code == `RTMOC_MC_SEL_SHUTDOWN) || (c.code == `RTMOC_MC_SEL_OVERRIDE);
   endfunction

   // rst_b and master_reset_n both clear everything, the register soft reset only bus, staging and pending code 8 reset state
   assign hardRst_b = rst_b && master_reset_n;

   rtmoc_skid_buf #(
      .WIDTH (`RTMOC_WORD_W),
      .DEPTH (BUF_DEPTH)
   ) u_buf (
      .clk      (clk),
      .rst_b    (hardRst_b),
      .inValid  (rxWordValid),
      .inData   (rxWord),
      .inReady  (rxWordReady),
      .outValid (bufOutValid),
      .outData  (bufOutData),
      .outReady (bufPop)
   );

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      next_s           = s;
      next_s.rdData    = `RTMOC_RESET_WORD;
      next_s.bitReq    = 1'b0;
      next_s.stsOnly   = 1'b0;
      next_s.termReset = 1'b0;
      bufPop           = 1'b0;
      outFree          = !s.memWrValid || memWrReady;
      // live option bit: a change mid-message is the host's hazard
      stagingOn        = s.opt[`RTMOC_OPT_RX_STAGING_BUFFER_EN];
      hostBsd          = s.opt[`RTMOC_OPT_HOST_HANDLED_SHUTDOWN];
      softRst          = regWr && (regAddr == `RTMOC_ADDR_STS) &&
                         regWdata[`RTMOC_STS_TERMINAL_SOFT_RESET];
      termRst          = softRst;

      if (s.memWrValid && memWrReady) begin
         next_s.memWrValid = 1'b0;
      end

      if (regWr) begin
         case (regAddr)
            `RTMOC_ADDR_CFG1: next_s.cfg1    = regWdata;
            `RTMOC_ADDR_OPT:  next_s.opt     = regWdata & `RTMOC_OPT_MASK;
            `RTMOC_ADDR_BITW: next_s.bitLow  = regWdata[11:0];
            `RTMOC_ADDR_ALTW: next_s.altWord = regWdata;
            default: ;
         endcase
      end

      if (regRd) begin
         case (regAddr)
            `RTMOC_ADDR_CFG1: next_s.rdData = s.cfg1;
            `RTMOC_ADDR_STS:  next_s.rdData = {7'h00, s.stage == STG_COPY,
                                               s.txOffA, s.txOffB, s.rxOffA, s.rxOffB, 4'h0};
            `RTMOC_ADDR_OPT:  next_s.rdData = s.opt;
            `RTMOC_ADDR_BITW: next_s.rdData = {s.txOffA, s.txOffB, s.rxOffA, s.rxOffB,
                                               s.bitLow};
            `RTMOC_ADDR_ALTW: next_s.rdData = s.altWord;
            default:          next_s.rdData = `RTMOC_RESET_WORD;
         endcase
      end

      // ****************************************************************
      // receive data path
      // ****************************************************************
      case (s.stage)
         STG_FILL: begin
            if (bufOutValid && stagingOn) begin
               // words past the buffer size are dropped, a legal message never has them
               if (s.cnt < CW'(STAGE_DEPTH)) begin
                  next_s.stageMem[s.cnt[CW-2:0]] = bufOutData;
                  next_s.cnt = s.cnt + 1'b1;
               end
               bufPop = 1'b1;
            end else if (bufOutValid && outFree) begin
               next_s.memWrValid = 1'b1;
               next_s.memWr      = '{idx: 5'(s.cnt), data: bufOutData};
               next_s.cnt        = s.cnt + 1'b1;
               bufPop            = 1'b1;
            end
            // the end of a message is acted on only once its words left the fifo
            if (s.endPend && !bufOutValid) begin
               next_s.endPend = 1'b0;
               if (stagingOn && !s.endErr && (s.cnt != '0)) begin
                  next_s.stage   = STG_COPY;
                  next_s.copyIdx = '0;
               end else begin
                  next_s.cnt = '0;
               end
            end
         end
         STG_COPY: begin
            // the fifo is not drained here, so the next message is back-pressured
            if (outFree) begin
               next_s.memWrValid = 1'b1;
               next_s.memWr      = '{idx: 5'(s.copyIdx),
                                     data: s.stageMem[s.copyIdx[CW-2:0]]};
               next_s.copyIdx    = s.copyIdx + 1'b1;
               if (s.copyIdx == s.cnt - 1'b1) begin
                  next_s.stage = STG_FILL;
                  next_s.cnt   = '0;
               end
            end
         end
         default: next_s.stage = STG_FILL;
      endcase

      if (msgEnd) begin
         next_s.endPend = 1'b1;
         next_s.endErr  = msgErr;
      end

      // ****************************************************************
      // mode commands
      // ****************************************************************
      if (mcValid) begin
         if (isBusCmd(mc) && hostBsd) begin
            next_s.stsOnly = 1'b1;
         end
         if (!hostBsd && isShutdown(mc)) begin
            // the arrival bus is never touched, only the other one
            if (mc.bus) begin
               next_s.txOffA = 1'b1;
               next_s.rxOffA = s.rxOffA || !s.cfg1[`RTMOC_CFG1_SHUTDOWN_TX_ONLY];
            end else begin
               next_s.txOffB = 1'b1;
               next_s.rxOffB = s.rxOffB || !s.cfg1[`RTMOC_CFG1_SHUTDOWN_TX_ONLY];
            end
         end
         if (!hostBsd && isOverride(mc)) begin
            if (mc.bus) begin
               next_s.txOffA = 1'b0;
               next_s.rxOffA = 1'b0;
            end else begin
               next_s.txOffB = 1'b0;
               next_s.rxOffB = 1'b0;
            end
         end
         if (mc.code == `RTMOC_MC_TX_SELFTEST_WORD) begin
            next_s.bitReq = 1'b1;
         end
         if ((mc.code == `RTMOC_MC_RESET_TERMINAL) &&
             !s.opt[`RTMOC_OPT_AUTO_RESET_ON_CODE8_OFF]) begin
            if (mc.bcast) begin
               termRst = 1'b1;
            end else begin
               next_s.resetPend = 1'b1;
            end
         end
      end

      if (statusDone && s.resetPend) begin
         termRst = 1'b1;
      end

      if (termRst) begin
         next_s.txOffA    = 1'b0;
         next_s.txOffB    = 1'b0;
         next_s.rxOffA    = 1'b0;
         next_s.rxOffB    = 1'b0;
         next_s.stage     = STG_FILL;
         next_s.cnt       = '0;
         next_s.endPend   = 1'b0;
         next_s.resetPend = 1'b0;
         next_s.termReset = 1'b1;
      end

      // ****************************************************************
      // outputs
      // ****************************************************************
      // host inhibit bits and pins act in every mode, the host's tool when it owns shutdown
      next_s.txEnA = !next_s.txOffA && !next_s.cfg1[`RTMOC_CFG1_TX_INHIBIT_BUS_A] &&
                     !txInhibitPinA;
      next_s.txEnB = !next_s.txOffB && !next_s.cfg1[`RTMOC_CFG1_TX_INHIBIT_BUS_B] &&
                     !txInhibitPinB;
      next_s.rxEnA = !next_s.rxOffA;
      next_s.rxEnB = !next_s.rxOffB;
      if (next_s.opt[`RTMOC_OPT_ALT_SELFTEST_WORD_SEL]) begin
         next_s.bitWordOut = next_s.altWord;
      end else begin
         next_s.bitWordOut = {next_s.txOffA, next_s.txOffB, next_s.rxOffA, next_s.rxOffB,
                              next_s.bitLow};
      end
   end

   always_ff @(posedge clk) begin
      if (!hardRst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign regRdata       = s.rdData;
   assign memWrValid     = s.memWrValid;
   assign memWr          = s.memWr;
   assign txEnA          = s.txEnA;
   assign txEnB          = s.txEnB;
   assign rxEnA          = s.rxEnA;
   assign rxEnB          = s.rxEnB;
   assign bitWordOut     = s.bitWordOut;
   assign bitWordReq     = s.bitReq;
   assign statusOnlyResp = s.stsOnly;
   assign terminalReset  = s.termReset;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!hardRst_b);

   property p_stage_hold;
      s.opt[`RTMOC_OPT_RX_STAGING_BUFFER_EN] && s.stage == STG_FILL && !s.memWrValid &&
      !regWr |=> !s.memWrValid;
   endproperty
   a_stage_hold: assert property (p_stage_hold) else $error("write while staging");

   property p_discard;
      s.stage == STG_FILL && s.endPend && s.endErr && !bufOutValid && !msgEnd
      |=> s.stage == STG_FILL && s.cnt == '0;
   endproperty
   a_discard: assert property (p_discard) else $error("errored message not dropped");

   property p_default_word;
      !s.opt[`RTMOC_OPT_ALT_SELFTEST_WORD_SEL] |->
      bitWordOut == {s.txOffA, s.txOffB, s.rxOffA, s.rxOffB, s.bitLow};
   endproperty
   a_default_word: assert property (p_default_word) else $error("bad default word");

   property p_alt_word;
      s.opt[`RTMOC_OPT_ALT_SELFTEST_WORD_SEL] |-> bitWordOut == s.altWord;
   endproperty
   a_alt_word: assert property (p_alt_word) else $error("bad alternate word");

   property p_arrival_bus_kept;
      mcValid && isShutdown(mc) && !mc.bus && !s.txOffA |=> !s.txOffA;
   endproperty
   a_arrival_bus_kept: assert property (p_arrival_bus_kept) else $error("arrival bus shut");

   property p_auto_shut;
      mcValid && isShutdown(mc) && !hostBsd && !mc.bus && !regWr
      |=> !txEnB && (rxEnB == $past(!s.rxOffB && s.cfg1[`RTMOC_CFG1_SHUTDOWN_TX_ONLY]));
   endproperty
   a_auto_shut: assert property (p_auto_shut) else $error("inactive bus not shut");

   property p_tx_inhibit;
      s.txOffA |-> !txEnA && (bitWordOut[15] || s.opt[`RTMOC_OPT_ALT_SELFTEST_WORD_SEL]);
   endproperty
   a_tx_inhibit: assert property (p_tx_inhibit) else $error("shut bus transmits");

   property p_host_only;
      mcValid && isBusCmd(mc) && hostBsd && !regWr
      |=> statusOnlyResp && $stable({s.txOffA, s.txOffB, s.rxOffA, s.rxOffB});
   endproperty
   a_host_only: assert property (p_host_only) else $error("acted while host-handled");

   property p_override;
      mcValid && isOverride(mc) && !hostBsd && !mc.bus
      |=> !s.txOffB && !s.rxOffB && rxEnB;
   endproperty
   a_override: assert property (p_override) else $error("override failed");

   property p_code8_wait;
      s.resetPend && !statusDone && !regWr && !mcValid |=> !terminalReset ##0 s.resetPend;
   endproperty
   a_code8_wait: assert property (p_code8_wait) else $error("early terminal reset");

   property p_code8_fire;
      statusDone && s.resetPend |=> terminalReset && !s.txOffA && !s.txOffB;
   endproperty
   a_code8_fire: assert property (p_code8_fire) else $error("reset not done");

   c_copy: cover property (s.stage == STG_FILL ##1 s.stage == STG_COPY);
   c_shut: cover property (mcValid && isShutdown(mc) && !hostBsd ##1 !txEnB);
   c_reset: cover property (s.resetPend ##[1:20] terminalReset);
endmodule

// file: tb/rtmoc_mem_sink.sv
// memory write receiver model that logs every accepted word and can stall
`timescale 1ns/1ns
module rtmoc_mem_sink (
   input  wire logic                    clk,
   input  wire logic                    stall,
   input  wire logic                    memWrValid,
   input  wire rtmoc_pkg::rtmoc_memwr_t memWr,
   output logic                         memWrReady
);
   import rtmoc_pkg::*;
   rtmoc_memwr_t log [64];
   int           count = 0;
   // a stalled memory holds ready low, so the receive path has to back up
   assign memWrReady = !stall;
   always @(posedge clk) begin
      if (memWrValid && memWrReady) begin
         log[count % 64] <= memWr;
         count <= count + 1;
      end
   end
endmodule

// file: tb/rtmoc_top_test.sv
// self-checking bench for the rt option control block
`timescale 1ns/1ns
`include "rtmoc_map.svh"
module rtmoc_top_test;
   import rtmoc_pkg::*;
   logic         clk = 0, rst_b = 0, mrN = 1, stall = 0;
   logic [5:0]   regAddr = '0;
   logic [15:0]  regWdata = '0, rxWord = '0, regRdata, bitWordOut;
   logic         regWr = 0, regRd = 0, rxWordValid = 0, msgEnd = 0, msgErr = 0;
   logic         mcValid = 0, statusDone = 0, rxWordReady, memWrValid, memWrReady;
   logic         txEnA, txEnB, rxEnA, rxEnB, bitWordReq, statusOnlyResp, terminalReset;
   logic         gotReq, gotSo;
   logic [1:0]   pins = '0;
   rtmoc_mc_t    mc = '0;
   rtmoc_memwr_t memWr;
   int           nMismatch = 0, checks = 0;

   always #4 clk = ~clk;

   rtmoc_top uut (.clk(clk), .rst_b(rst_b), .master_reset_n(mrN), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .rxWordValid(rxWordValid), .rxWord(rxWord), .rxWordReady(rxWordReady),
      .msgEnd(msgEnd), .msgErr(msgErr), .mcValid(mcValid), .mc(mc),
      .statusDone(statusDone), .txInhibitPinA(pins[1]), .txInhibitPinB(pins[0]),
      .memWrValid(memWrValid), .memWr(memWr), .memWrReady(memWrReady), .txEnA(txEnA),
      .txEnB(txEnB), .rxEnA(rxEnA), .rxEnB(rxEnB), .bitWordOut(bitWordOut),
      .bitWordReq(bitWordReq), .statusOnlyResp(statusOnlyResp),
      .terminalReset(terminalReset));
   rtmoc_mem_sink sink (.clk(clk), .stall(stall), .memWrValid(memWrValid), .memWr(memWr),
      .memWrReady(memWrReady));

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", checks, nMismatch);
      if (nMismatch == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
      checks++;
      if (got !== exp) begin
         nMismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk);
      regWr <= 1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWr <= 0;
   endtask
   task automatic rd(input logic [5:0] a, input logic [15:0] exp, input string what);
      @(posedge clk);
      regRd <= 1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 0;
      #1 chk(what, 21'(exp), 21'(regRdata));
   endtask
   task automatic mcmd(input logic [4:0] code, input logic bus, input logic match);
      @(posedge clk);
      mcValid <= 1;
      mc <= '{code: code, bus: bus, bcast: 1'b0, match: match};
      @(posedge clk);
      mcValid <= 0;
      #1 gotReq = bitWordReq;
      gotSo = statusOnlyResp;
   endtask
   task automatic ens(input logic [3:0] exp);
      chk("enables", 21'(exp), 21'({txEnA, txEnB, rxEnA, rxEnB}));
   endtask
   task automatic send(input logic [15:0] w, input logic last, input logic err);
      int n;
      @(posedge clk);
      rxWordValid <= 1;
      rxWord <= w;
      for (n = 0; n < 100; n++) begin
         @(negedge clk);
         if (rxWordReady === 1'b1)
            break;
      end
      @(posedge clk);
      rxWordValid <= 0;
      msgEnd <= last;
      msgErr <= err;
      @(posedge clk);
      msgEnd <= 0;
      if (n == 100) begin
         nMismatch++;
         print_verdict();
      end
   endtask
   task automatic waitw(input int n);
      for (int i = 0; i < 300 && sink.count < n; i++)
         @(posedge clk);
      chk("write count", 21'(n), 21'(sink.count));
      if (sink.count < n)
         print_verdict();
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_bitword;
      wr(`RTMOC_ADDR_ALTW, 16'h1234);
      wr(`RTMOC_ADDR_BITW, 16'h0ABC);
      rd(6'h05, 16'h0000, "unmapped read");
      mcmd(`RTMOC_MC_TX_SELFTEST_WORD, 0, 0);
      chk("default word", 21'h10ABC, 21'({gotReq, bitWordOut}));
      wr(`RTMOC_ADDR_OPT, 16'h0020);
      mcmd(`RTMOC_MC_TX_SELFTEST_WORD, 1, 0);
      chk("alternate word", 21'h11234, 21'({gotReq, bitWordOut}));
      wr(`RTMOC_ADDR_OPT, 16'h0000);
      $display("test self-test word done");
   endtask
   task automatic t_shutdown;
      mcmd(`RTMOC_MC_TX_SHUTDOWN, 0, 0);
      ens(4'b1010);
      rd(`RTMOC_ADDR_BITW, 16'h5ABC, "status bits");
      mcmd(`RTMOC_MC_TX_OVERRIDE, 0, 0);
      ens(4'b1111);
      rd(`RTMOC_ADDR_BITW, 16'h0ABC, "cleared bits");
      wr(`RTMOC_ADDR_CFG1, 16'h0800);
      mcmd(`RTMOC_MC_SEL_SHUTDOWN, 1, 0);
      ens(4'b1111);
      mcmd(`RTMOC_MC_SEL_SHUTDOWN, 1, 1);
      ens(4'b0111);
      mcmd(`RTMOC_MC_SEL_OVERRIDE, 1, 0);
      ens(4'b0111);
      mcmd(`RTMOC_MC_SEL_OVERRIDE, 1, 1);
      ens(4'b1111);
      mcmd(`RTMOC_MC_SEL_SHUTDOWN, 1, 1);
      ens(4'b0111);
      wr(`RTMOC_ADDR_STS, 16'h0001);
      repeat (2) @(posedge clk);
      #1 ens(4'b1111);
      wr(`RTMOC_ADDR_OPT, 16'h0010);
      mcmd(`RTMOC_MC_TX_SHUTDOWN, 0, 0);
      chk("status only", 21'h1F, 21'({gotSo, txEnA, txEnB, rxEnA, rxEnB}));
      wr(`RTMOC_ADDR_CFG1, 16'h2800);
      #1 ens(4'b0111);
      @(posedge clk);
      pins <= 2'b01;
      @(posedge clk);
      #1 ens(4'b0011);
      @(posedge clk);
      pins <= 2'b10;
      wr(`RTMOC_ADDR_CFG1, 16'h0800);
      #1 ens(4'b0111);
      @(posedge clk);
      pins <= 2'b00;
      wr(`RTMOC_ADDR_OPT, 16'h0000);
      $display("test shutdown done");
   endtask
   task automatic t_reset8;
      mcmd(`RTMOC_MC_TX_SHUTDOWN, 0, 0);
      mcmd(`RTMOC_MC_RESET_TERMINAL, 0, 0);
      repeat (3) @(posedge clk);
      #1 chk("early reset", 21'h0B, 21'({terminalReset, txEnA, txEnB, rxEnA, rxEnB}));
      rd(`RTMOC_ADDR_STS, 16'h0040, "status reg");
      @(posedge clk);
      statusDone <= 1;
      @(posedge clk);
      statusDone <= 0;
      #1 chk("terminal reset", 21'h1, 21'(terminalReset));
      repeat (2) @(posedge clk);
      #1 ens(4'b1111);
      $display("test code 8 done");
   endtask
   task automatic t_fill;
      int k;
      int idle;
      k = 0;
      idle = 0;
      stall <= 1;
      @(posedge clk);
      rxWordValid <= 1;
      rxWord <= 16'hC000;
      while (idle < 10 && k < 40) begin
         @(negedge clk);
         if (rxWordReady === 1'b1) begin
            @(posedge clk);
            k++;
            rxWord <= 16'(16'hC000 + k);
            idle = 0;
         end else
            idle++;
      end
      @(posedge clk);
      rxWordValid <= 0;
      stall <= 0;
      chk("held words", 21'(1), 21'(k == `RTMOC_BUF_DEPTH + 1 && sink.count == 0));
      waitw(k);
      for (int i = 0; i < k; i++)
         chk("order", 21'(16'hC000 + i), 21'(sink.log[i].data));
      $display("test buffer stall done");
   endtask
   task automatic t_stage;
      int b;
      b = sink.count;
      // staging changes only while execution is disabled
      wr(`RTMOC_ADDR_OPT, 16'h0040);
      for (int i = 0; i < 3; i++)
         send(16'(16'hA000 + i), i == 2, 1);
      repeat (20) @(posedge clk);
      chk("errored writes", 21'(b), 21'(sink.count));
      for (int i = 0; i < 3; i++)
         send(16'(16'hB000 + i), 0, 0);
      repeat (10) @(posedge clk);
      chk("early writes", 21'(b), 21'(sink.count));
      send(16'hB003, 1, 0);
      waitw(b + 4);
      for (int i = 0; i < 4; i++)
         chk("staged word", {5'(i), 16'(16'hB000 + i)}, 21'(sink.log[b + i]));
      $display("test staging done");
   endtask

   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1;
      repeat (2) @(posedge clk);
      #1 ens(4'b1111);
      rd(`RTMOC_ADDR_CFG1, 16'h0000, "cfg1 reset");
      t_bitword();
      t_shutdown();
      t_reset8();
      t_fill();
      t_stage();
      mcmd(`RTMOC_MC_TX_SHUTDOWN, 1, 0);
      ens(4'b0111);
      @(posedge clk);
      mrN <= 0;
      @(posedge clk);
      mrN <= 1;
      repeat (3) @(posedge clk);
      #1 ens(4'b1111);
      print_verdict();
   end
endmodule
